// ---- core/move_rotate_return_exec.v ----
`timescale 1ns/100ps
`default_nettype none
`include "move_rotate_return_map.vh"
module move_rotate_return_exec (
  // clock and reset
  input  wire                 i_clk_sys,
  input  wire                 i_reset,
  // decoded instruction
  input  wire                 i_op_valid,
  input  wire [2:0]           i_op_code,
  input  wire                 i_dest_bit,
  input  wire [`ADDR_W-1:0]   i_reg_addr,
  input  wire [`DATA_W-1:0]   i_literal,
  // data memory read (same clock, combinational read)
  input  wire [`DATA_W-1:0]   i_mem_rdata,
  // stack top from the stack block
  input  wire [`PC_W-1:0]     i_stack_top,
  // status in
  input  wire                 i_carry,
  // busy to the fetch stage
  output wire                 o_busy,
  // data memory write
  output reg                  o_mem_we,
  output reg  [`ADDR_W-1:0]   o_mem_addr,
  output reg  [`DATA_W-1:0]   o_mem_wdata,
  // working register
  output reg  [`DATA_W-1:0]   o_working_register,
  // flag updates
  output reg                  o_zero_we,
  output reg                  o_zero,
  output reg                  o_carry_we,
  output reg                  o_carry,
  output reg                  o_global_irq_enable_set,
  // program counter and stack pointer
  output reg                  o_pc_load,
  output reg  [`PC_W-1:0]     o_pc_value,
  output reg                  o_stack_pop
);

  // one op per cycle is taken while idle. copies and rotates finish
  // in the cycle after the taking edge; returns pop on that same cycle
  // and hold busy high through that one cycle so that fetch can
  // refill from the new program counter. busy is combinational from
  // the sequencer state so fetch sees it in the stall cycle itself.

  // sequencer states; a return holds fetch one cycle
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // sequencer state
  reg                state_ff;
  reg                nxt_state;
  // datapath result for the op at the inputs
  reg [`DATA_W-1:0]  result;
  reg                new_carry;
  // decode of the op at the inputs
  wire               take_op;
  wire               is_copy;
  wire               is_rotate;
  wire               is_return;
  wire               to_memory;
  // next values of the registered outputs
  reg                nxt_mem_we;
  reg [`ADDR_W-1:0]  nxt_mem_addr;
  reg [`DATA_W-1:0]  nxt_mem_wdata;
  reg [`DATA_W-1:0]  nxt_working_register;
  reg                nxt_zero_we;
  reg                nxt_zero;
  reg                nxt_carry_we;
  reg                nxt_carry;
  reg                nxt_irq_enable_set;
  reg                nxt_pc_load;
  reg [`PC_W-1:0]    nxt_pc_value;
  reg                nxt_stack_pop;

  // rotate helpers, carry in at the free end, carry out on top
  function [`DATA_W:0] rot_left;
    input [`DATA_W-1:0] src;
    input               cin;
    begin
      // left rotate mapping
      // bit 7 leaves through carry
      rot_left = {src[7], src[6:0], cin};
    end
  endfunction

  function [`DATA_W:0] rot_right;
    input [`DATA_W-1:0] src;
    input               cin;
    begin
      // right rotate mapping
      // bit 0 leaves through carry
      rot_right = {src[0], cin, src[7:1]};
    end
  endfunction

  // true for either rotate code
  function rotate_code;
    input [2:0] code;
    begin
      rotate_code = (code == `OP_ROT_LEFT) ||
                    (code == `OP_ROT_RIGHT);
    end
  endfunction

  // true for any of the three stack returns
  function return_code;
    input [2:0] code;
    begin
      return_code = (code == `OP_RET_PLAIN) ||
                    (code == `OP_RET_LIT) ||
                    (code == `OP_RET_IRQ);
    end
  endfunction

  // zero test shared by flag logic
  function zero_value;
    input [`DATA_W-1:0] value;
    begin
      zero_value = (value == {`DATA_W{1'b0}});
    end
  endfunction

  // an op is taken only while the sequencer is idle;
  // anything offered during the stall is dropped, not queued
  assign take_op   = i_op_valid && (state_ff == ST_IDLE);
  assign is_copy   = take_op && (i_op_code == `OP_COPY);
  assign is_rotate = take_op && rotate_code(i_op_code);
  assign is_return = take_op && return_code(i_op_code);
  // destination bit high sends the result back to memory
  // the destination bit is read only by copies and rotates
  assign to_memory = i_dest_bit;

  // returns take a second cycle; fetch is held
  assign o_busy = (state_ff == ST_WAIT);

  // result and carry selection; memory read is combinational,
  // so the result is ready within the taking cycle
  // rotates carry out on the top bit of the helper
  always @* begin
    result    = i_mem_rdata;
    new_carry = i_carry;
    case (i_op_code)
      `OP_ROT_LEFT: begin
        {new_carry, result} = rot_left(i_mem_rdata, i_carry);
      end
      `OP_ROT_RIGHT: begin
        {new_carry, result} = rot_right(i_mem_rdata, i_carry);
      end
      default: begin
        result    = i_mem_rdata;
        new_carry = i_carry;
      end
    endcase
  end

  // second cycle of returns
  // the stall cycle ends unconditionally; nothing can extend it
  always @* begin
    nxt_state = ST_IDLE;
    case (state_ff)
      ST_IDLE: begin
        if (is_return) begin
          nxt_state = ST_WAIT;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // memory write path; address and data hold between writes
  // a copy and a rotate never overlap, so the branches never fight
  always @* begin
    nxt_mem_we    = 1'b0;
    nxt_mem_addr  = o_mem_addr;
    nxt_mem_wdata = o_mem_wdata;
    if (is_copy && to_memory) begin
      nxt_mem_we    = 1'b1;
      nxt_mem_addr  = i_reg_addr;
      nxt_mem_wdata = result;
    end
    if (is_rotate && to_memory) begin
      nxt_mem_we    = 1'b1;
      nxt_mem_addr  = i_reg_addr;
      nxt_mem_wdata = result;
    end
  end

  // working register; holds unless an op targets it
  // op codes are exclusive, so at most one branch applies
  always @* begin
    nxt_working_register = o_working_register;
    if (is_copy && !to_memory) begin
      nxt_working_register = result;
    end
    if (is_rotate && !to_memory) begin
      nxt_working_register = result;
    end
    if (is_return && (i_op_code == `OP_RET_LIT)) begin
      nxt_working_register = i_literal;
    end
  end

  // flag writes; each op touches only its own flag
  // the carry input is the current flag, read only by rotates
  always @* begin
    nxt_zero_we  = 1'b0;
    nxt_zero     = o_zero;
    nxt_carry_we = 1'b0;
    nxt_carry    = o_carry;
    if (is_copy) begin
      nxt_zero_we = 1'b1;
      nxt_zero    = zero_value(result);
    end
    if (is_rotate) begin
      nxt_carry_we = 1'b1;
      nxt_carry    = new_carry;
    end
  end

  // return controls; returns leave every status flag alone
  // the stack block decrements its pointer on the pop pulse;
  // the program counter value holds so fetch may read it late
  always @* begin
    nxt_pc_load        = 1'b0;
    nxt_pc_value       = o_pc_value;
    nxt_stack_pop      = 1'b0;
    nxt_irq_enable_set = 1'b0;
    if (is_return) begin
      nxt_pc_load  = 1'b1;
      nxt_pc_value = i_stack_top;
      nxt_stack_pop = 1'b1;
    end
    if (is_return && (i_op_code == `OP_RET_IRQ)) begin
      nxt_irq_enable_set = 1'b1;
    end
  end

  // sequencer register; reset drops any pending stall
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // memory write registers; the strobe is a one-cycle pulse
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= {`ADDR_W{1'b0}};
      o_mem_wdata <= `DATA_RST;
    end else begin
      o_mem_we    <= nxt_mem_we;
      o_mem_addr  <= nxt_mem_addr;
      o_mem_wdata <= nxt_mem_wdata;
    end
  end

  // working register
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_working_register <= `DATA_RST;
    end else begin
      o_working_register <= nxt_working_register;
    end
  end

  // flag registers; value outputs hold, enables pulse
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_zero_we  <= 1'b0;
      o_zero     <= 1'b0;
      o_carry_we <= 1'b0;
      o_carry    <= 1'b0;
    end else begin
      o_zero_we  <= nxt_zero_we;
      o_zero     <= nxt_zero;
      o_carry_we <= nxt_carry_we;
      o_carry    <= nxt_carry;
    end
  end

  // program counter, stack and interrupt enable pulses
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pc_load               <= 1'b0;
      o_pc_value              <= `PC_RST;
      o_stack_pop             <= 1'b0;
      o_global_irq_enable_set <= 1'b0;
    end else begin
      o_pc_load               <= nxt_pc_load;
      o_pc_value              <= nxt_pc_value;
      o_stack_pop             <= nxt_stack_pop;
      o_global_irq_enable_set <= nxt_irq_enable_set;
    end
  end

endmodule
`default_nettype wire

// ---- core/move_rotate_return_map.vh ----
// How it works
// - copy register to working or itself
// - copy updates zero flag from value
// - literal return loads working, pops pc
// - plain return pops pc, two cycles
// - rotate left through carry bit mapping
// - rotate right through carry bit mapping
// - rotate left destination, only carry changes
// - rotate right destination, only carry changes
`ifndef MOVE_ROTATE_RETURN_MAP_VH
`define MOVE_ROTATE_RETURN_MAP_VH
// operation select codes
`define OP_NONE      3'h0
`define OP_COPY      3'h1
`define OP_ROT_LEFT  3'h2
`define OP_ROT_RIGHT 3'h3
`define OP_RET_PLAIN 3'h4
`define OP_RET_LIT   3'h5
`define OP_RET_IRQ   3'h6
// widths and reset values
`define DATA_W       8
`define ADDR_W       7
`define PC_W         11
`define SP_W         4
`define DATA_RST     8'h00
`define PC_RST       11'h000
`endif

// ---- sim/move_rotate_return_exec_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module move_rotate_return_exec_asserts (
  input wire logic i_clk_sys, i_reset, i_op_valid, i_dest_bit, i_carry,
  input wire logic [2:0] i_op_code,
  input wire logic [7:0] i_mem_rdata, i_literal, o_working_register,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [10:0] i_stack_top, o_pc_value,
  input wire logic o_busy, o_mem_we, o_zero_we, o_zero, o_carry_we,
  input wire logic o_carry, o_global_irq_enable_set, o_stack_pop
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // code of the op taken at this edge; a stalled request reads as none
  wire logic [2:0] op = i_op_valid && !o_busy ? i_op_code : 3'h0;
  a_copy_work: assert property (op == 1 && !i_dest_bit |=>
    o_working_register == $past(i_mem_rdata)) else $error("copy");
  a_copy_zero: assert property (op == 1 |=> o_zero_we &&
    o_zero == ($past(i_mem_rdata) == 8'h00)) else $error("zero");
  a_irq_exit: assert property (op == 6 |=> o_global_irq_enable_set
    && o_pc_value == $past(i_stack_top)) else $error("irq");
  a_lit_ret: assert property (op == 5 |=> !o_zero_we && !o_carry_we
    && o_working_register == $past(i_literal)) else $error("lit");
  a_ret_stall: assert property (op == 4 |=> o_busy ##1 !o_busy)
    else $error("stall");
  a_rol_mem: assert property (op == 2 && i_dest_bit |=>
    o_mem_we && !o_zero_we && {o_carry, o_mem_wdata} ==
    {$past(i_mem_rdata), $past(i_carry)}) else $error("rol");
  a_ror_work: assert property (op == 3 && !i_dest_bit |=>
    !o_mem_we && {o_working_register, o_carry} ==
    {$past(i_carry), $past(i_mem_rdata)}) else $error("ror");
  a_pop_once: assert property (op > 3 |=> o_stack_pop ##1 !o_stack_pop)
    else $error("pop");
endmodule
`default_nettype wire

// ---- sim/exec_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module exec_partner (
  input wire logic i_clk_sys, o_mem_we, o_stack_pop,
  input wire logic [6:0] i_reg_addr, o_mem_addr,
  input wire logic [7:0] o_mem_wdata,
  output logic [7:0] i_mem_rdata,
  output logic [10:0] i_stack_top
);
  logic [7:0] mem [128];
  logic [1:0] sp = 2'h3;
  // pointer in the low bits, so a missed pop shows in the address
  assign i_mem_rdata = mem[i_reg_addr];
  assign i_stack_top = {9'h0a5, sp};
  // writes and pops land on the edge
  always @(posedge i_clk_sys) begin
    if (o_mem_we) mem[o_mem_addr] <= o_mem_wdata;
    if (o_stack_pop) sp <= sp - 2'h1;
  end
endmodule
`default_nettype wire

// ---- sim/move_rotate_return_exec_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "move_rotate_return_map.vh"
module move_rotate_return_exec_bench;
  logic i_clk_sys = 1'h0, i_reset = 1'h1, i_op_valid = 1'h0;
  logic i_dest_bit = 1'h0, i_carry = 1'h0, o_busy, o_mem_we, o_zero_we;
  logic o_zero, o_carry_we, o_carry, o_global_irq_enable_set, o_pc_load;
  logic o_stack_pop;
  logic [2:0] i_op_code = 3'h0;
  logic [6:0] i_reg_addr = 7'h05, o_mem_addr;
  logic [7:0] i_literal = 8'h00, i_mem_rdata, o_mem_wdata;
  logic [7:0] o_working_register;
  logic [10:0] i_stack_top, o_pc_value;
  int num_errors = 0, check_count = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  move_rotate_return_exec dut_u (.*);
  exec_partner mp (.*);
  task automatic chk(string n, logic [23:0] s, e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // an idle cycle that covers a previous return's stall, then one op
  task automatic run(logic [2:0] c, logic d, logic [7:0] l, logic y);
    @(posedge i_clk_sys);
    {i_op_valid, i_op_code, i_dest_bit, i_literal, i_carry} <=
      {1'h1, c, d, l, y};
    @(posedge i_clk_sys);
    i_op_valid <= 1'h0;
    #1 $display("op %0d done", c);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    mp.mem[5] = 8'h80;
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    run(`OP_ROT_LEFT, 1'h1, 8'h00, 1'h0);
    chk("rol", {o_mem_we, o_carry, o_mem_addr, o_mem_wdata},
      17'h1_8500);
    run(`OP_COPY, 1'h1, 8'h00, 1'h0);
    chk("copy", {o_mem_we, o_zero_we, o_zero}, 3'h7);
    run(`OP_ROT_RIGHT, 1'h0, 8'h00, 1'h1);
    chk("ror", {o_mem_we, o_carry, o_working_register}, 10'h080);
    run(`OP_RET_PLAIN, 1'h0, 8'h00, 1'h0);
    chk("ret", {o_busy, o_stack_pop, o_pc_load, o_pc_value}, 14'h3a97);
    run(`OP_RET_LIT, 1'h0, 8'h55, 1'h0);
    chk("lit", {o_working_register, o_pc_value}, 19'h2aa96);
    run(`OP_RET_IRQ, 1'h0, 8'h00, 1'h0);
    chk("irq", {o_global_irq_enable_set, o_pc_value}, 12'ha95);
    // an op offered in a return's stall is refused
    @(posedge i_clk_sys);
    {i_op_valid, i_op_code} <= {1'h1, `OP_RET_PLAIN};
    @(posedge i_clk_sys);
    i_op_code <= `OP_COPY;
    @(posedge i_clk_sys);
    i_op_valid <= 1'h0;
    #1 $display("refuse done");
    chk("refuse", {o_busy, o_zero_we, o_pc_load,
      o_working_register, o_pc_value}, 24'h02_aa94);
    // a mid-run reset clears outputs; an op may follow at once
    @(posedge i_clk_sys);
    i_reset <= 1'h1;
    mp.mem[5] = 8'h3c;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'h0;
    #1 $display("reset done");
    chk("reset", {o_busy, o_mem_we, o_pc_load,
      o_working_register, o_pc_value}, 24'h00_0000);
    run(`OP_COPY, 1'h0, 8'h00, 1'h0);
    chk("copy_w", {o_mem_we, o_zero_we, o_zero,
      o_working_register}, 11'h23c);
    run(`OP_ROT_LEFT, 1'h0, 8'h00, 1'h1);
    chk("rol_w", {o_mem_we, o_carry_we, o_carry,
      o_working_register}, 11'h279);
    run(`OP_ROT_RIGHT, 1'h1, 8'h00, 1'h1);
    chk("ror_m", {o_zero_we, o_mem_we, o_carry_we, o_carry,
      o_mem_wdata}, 12'h69e);
    results();
  end
endmodule
bind move_rotate_return_exec move_rotate_return_exec_asserts chk_u (.*);
`default_nettype wire
